// >>> include/eee_pkg.sv
// constants for the energy-efficient ethernet low-power-idle controller
// -----------------------------------------------------------------
// Notes on behaviour
// - tx off for quiet periods of 20 ms
// - device starts periodic refresh cycles itself
// - quiet/refresh repeats until the local side wakes, or at 1000m until either side wakes
// - config bit selects reduced-amplitude 10 mbit mode
// - marginal link reverts to standard amplitude automatically
// - 100m idle request starts line idle signalling
// - 100m partner idle powers down receive path
// - 100m any wake restores normal per direction
// - 100m rx idle: dv low, er high, 0001
// - 100m wake completes within 30 us
// - 1000m quiet only after sleep sent and received
// - 1000m no partner idle keeps transmitter active
// - 1000m idle requests passed to far end
// - 1000m idle reported per direction to mac
// - 1000m rx idle: dv low, er high, 01
// - 1000m wake completes within 16.5 us
// -----------------------------------------------------------------
package eee_pkg;
   // clock rate
   localparam int CLK_MHZ = 200;
   // quiet period in ms and its cycle count
   localparam int QUIET_MS = 20;
   localparam int QUIET_CYC = QUIET_MS * 1000 * CLK_MHZ;
   // refresh burst length in cycles (plain choice)
   localparam int REFRESH_CYC = 64;
   // wake times in ns, cycles rounded down as a longest time
   localparam int WAKE100_NS = 30000;
   localparam int WAKE1000_NS = 16500;
   localparam int WAKE100_CYC = WAKE100_NS * CLK_MHZ / 1000;
   localparam int WAKE1000_CYC = WAKE1000_NS * CLK_MHZ / 1000;
   // counter width
   localparam int CNT_W = 32;
   // idle encodings on the mii data lanes
   localparam logic [7:0] LPI_CODE_1000 = 8'h01;
   localparam logic [3:0] LPI_CODE_100 = 4'h1;
   // speed selector codes
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // transmit line states
   typedef enum logic [2:0] {
      EEE_ACTIVE, EEE_SLEEP, EEE_QUIET, EEE_REFRESH, EEE_WAKE
   } eee_tx_e;
endpackage : eee_pkg

// >>> src/eee_lpi_ctrl.sv
// low-power-idle transmit/receive control of the phy
`timescale 1ns/1ps
module eee_lpi_ctrl
   import eee_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC,
   parameter int WAKE100_CYCLES = WAKE100_CYC,
   parameter int WAKE1000_CYCLES = WAKE1000_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // configuration
   input wire logic [1:0] speed_sel,
   input wire logic ten_meg_reduced_amplitude_enable,
   // mac transmit side
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [7:0] txd,
   // line status from the pcs (async)
   input wire logic partner_sleep,
   input wire logic partner_lpi,
   input wire logic link_marginal,
   input wire logic [7:0] rx_line_data,
   input wire logic rx_line_dv,
   input wire logic rx_line_er,
   // mac receive side
   output logic rx_dv,
   output logic rx_er,
   output logic [7:0] rxd,
   // line control
   output logic tx_quiet,
   output logic tx_refresh,
   output logic tx_send_sleep,
   output logic tx_lpi_to_far,
   output logic rx_path_off,
   output logic tx_lpi_status,
   output logic rx_lpi_status,
   output logic wake_done,
   output logic ten_reduced_active
);
   // -----------------------------------------------------------------
   // synchronised line inputs
   // -----------------------------------------------------------------
   logic p_sleep_s; // partner sent sleep
   logic p_lpi_s; // partner in idle
   logic marg_s; // marginal link detected
   eee_sync u_sync_sleep (
      .clock(clock),
      .resetn(resetn),
      .din(partner_sleep),
      .dout(p_sleep_s)
   );
   eee_sync u_sync_lpi (
      .clock(clock),
      .resetn(resetn),
      .din(partner_lpi),
      .dout(p_lpi_s)
   );
   eee_sync u_sync_marg (
      .clock(clock),
      .resetn(resetn),
      .din(link_marginal),
      .dout(marg_s)
   );

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire is_100 = (speed_sel == SPD_100);
   wire is_1000 = (speed_sel == SPD_1000);
   wire eee_speed = is_100 | is_1000;
   // mac idle requests per speed
   wire req_100 = is_100 & ~tx_en & tx_er & (txd[3:0] == LPI_CODE_100);
   wire req_1000 = is_1000 & ~tx_en & tx_er & (txd == LPI_CODE_1000);
   wire tx_req = req_100 | req_1000;
   // any removal of the encoding wakes the transmit side
   wire tx_wake = ~tx_req;
   // partner wake also ends the quiet cycle, at 1000m only
   wire rx_wake = ~p_lpi_s;
   // 1000m quiet needs both sleeps
   wire both_sleep = p_sleep_s;
   // wake budget for the current speed
   wire [CNT_W-1:0] wake_lim = is_1000 ? CNT_W'(WAKE1000_CYCLES) : CNT_W'(WAKE100_CYCLES);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   eee_tx_e st_q; // transmit line state
   eee_tx_e st_d; // next state
   logic [CNT_W-1:0] cnt_q; // period counter
   logic [CNT_W-1:0] cnt_d; // next count
   wire cnt_quiet_end = (cnt_q >= CNT_W'(QUIET_CYCLES - 1));
   wire cnt_ref_end = (cnt_q >= CNT_W'(REFRESH_CYC - 1));
   wire cnt_wake_end = (cnt_q >= wake_lim - CNT_W'(1));

   // next-state logic
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + CNT_W'(1);
      case (st_q)
         // normal idle symbols or data
         EEE_ACTIVE: begin
            cnt_d = '0;
            if (tx_req) begin
               // 100m goes straight to quiet, 1000m sends sleep first
               st_d = is_1000 ? EEE_SLEEP : EEE_QUIET;
            end
         end
         // 1000m: sleep sent, waiting for partner sleep
         EEE_SLEEP: begin
            cnt_d = '0;
            if (tx_wake) begin
               st_d = EEE_ACTIVE;
            end else if (both_sleep) begin
               st_d = EEE_QUIET;
            end
            // otherwise stay non-quiet
         end
         // transmitter off
         EEE_QUIET: begin
            if (tx_wake || (is_1000 && rx_wake)) begin
               st_d = EEE_WAKE;
               cnt_d = '0;
            end else if (cnt_quiet_end) begin
               st_d = EEE_REFRESH;
               cnt_d = '0;
            end
         end
         // self-started refresh
         EEE_REFRESH: begin
            if (tx_wake || (is_1000 && rx_wake)) begin
               st_d = EEE_WAKE;
               cnt_d = '0;
            end else if (cnt_ref_end) begin
               st_d = EEE_QUIET;
               cnt_d = '0;
            end
         end
         // wake: bounded by the speed wake time
         EEE_WAKE: begin
            if (cnt_wake_end) begin
               st_d = EEE_ACTIVE;
               cnt_d = '0;
            end
         end
         default: begin
            st_d = EEE_ACTIVE;
            cnt_d = '0;
         end
      endcase
      // leaving an eee speed drops everything
      if (!eee_speed) begin
         st_d = EEE_ACTIVE;
         cnt_d = '0;
      end
   end

   // -----------------------------------------------------------------
   // receive side decode
   // -----------------------------------------------------------------
   // receive idle per direction, ends on any partner wake
   wire rx_idle = eee_speed & p_lpi_s;
   wire [7:0] rx_code = is_1000 ? LPI_CODE_1000 : {4'h0, LPI_CODE_100};
   wire [7:0] rxd_d = rx_idle ? rx_code : rx_line_data;
   wire rx_dv_d = rx_idle ? 1'b0 : rx_line_dv;
   wire rx_er_d = rx_idle ? 1'b1 : rx_line_er;
   // reduced amplitude unless marginal link
   wire ten_red_d = ten_meg_reduced_amplitude_enable & ~marg_s;

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // state and counter
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_q <= EEE_ACTIVE;
         cnt_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // line control outputs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_quiet <= 1'b0;
         tx_refresh <= 1'b0;
         tx_send_sleep <= 1'b0;
         tx_lpi_to_far <= 1'b0;
         tx_lpi_status <= 1'b0;
         wake_done <= 1'b0;
      end else begin
         tx_quiet <= (st_d == EEE_QUIET);
         tx_refresh <= (st_d == EEE_REFRESH);
         tx_send_sleep <= (st_d == EEE_SLEEP);
         // request passed on even when line stays active
         tx_lpi_to_far <= tx_req;
         tx_lpi_status <= (st_d != EEE_ACTIVE) && (st_d != EEE_WAKE);
         // one-cycle pulse when wake finishes
         wake_done <= (st_q == EEE_WAKE) && (st_d == EEE_ACTIVE);
      end
   end

   // receive outputs toward mac
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
         rxd <= 8'h00;
         rx_path_off <= 1'b0;
         rx_lpi_status <= 1'b0;
         ten_reduced_active <= 1'b0;
      end else begin
         rx_dv <= rx_dv_d;
         rx_er <= rx_er_d;
         rxd <= rxd_d;
         rx_path_off <= rx_idle;
         rx_lpi_status <= rx_idle;
         ten_reduced_active <= ten_red_d;
      end
   end
endmodule : eee_lpi_ctrl

// >>> src/eee_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module eee_sync
   import eee_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // async level in, settled level out
   input wire logic din,
   output logic dout
);
   // -----------------------------------------------------------------
   // stages
   // -----------------------------------------------------------------
   logic s1_q; // first stage, read only by s2
   logic s2_q; // second stage
   logic s3_q; // third stage
   wire agree = (s2_q == s3_q); // stable once the last two agree
   // shift chain and settled output
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            dout <= s3_q;
         end
      end
   end
endmodule : eee_sync

// >>> tb/eee_lpi_ctrl_asserts.sv
// port assertions of the low-power-idle controller
`timescale 1ns/1ps
module eee_lpi_ctrl_asserts
   import eee_pkg::*;
#(
   parameter int WAKE100_CYCLES = WAKE100_CYC,
   parameter int WAKE1000_CYCLES = WAKE1000_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // configuration and mac transmit
   input wire logic [1:0] speed_sel,
   input wire logic ten_meg_reduced_amplitude_enable,
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [7:0] txd,
   // watched outputs
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic [7:0] rxd,
   input wire logic tx_quiet,
   input wire logic tx_refresh,
   input wire logic tx_send_sleep,
   input wire logic tx_lpi_to_far,
   input wire logic rx_path_off,
   input wire logic tx_lpi_status,
   input wire logic rx_lpi_status,
   input wire logic wake_done,
   input wire logic ten_reduced_active
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   wire eee = (speed_sel == SPD_100) || (speed_sel == SPD_1000);
   wire code_ok = (speed_sel == SPD_1000) ? (txd == LPI_CODE_1000) : (txd[3:0] == LPI_CODE_100);
   wire req = !tx_en && tx_er && code_ok;
   logic qr_q, wk_q;
   logic [31:0] wk_cnt_q;
   wire [31:0] lim = 32'((speed_sel == SPD_1000) ? WAKE1000_CYCLES : WAKE100_CYCLES);
   // wake span opens when quiet or refresh ends, closes on wake_done
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         qr_q <= 1'b0;
         wk_q <= 1'b0;
         wk_cnt_q <= 32'h0;
      end else begin
         qr_q <= tx_quiet || tx_refresh;
         wk_q <= (wk_q || (qr_q && !tx_lpi_status)) && !wake_done;
         wk_cnt_q <= wk_q ? wk_cnt_q + 32'h1 : 32'h0;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_quiet_100;
      (speed_sel == SPD_100) && $rose(req) && !tx_lpi_status |=> tx_quiet;
   endproperty
   a_quiet_100: assert property (p_quiet_100) else $error("no quiet after request");
   // quiet entered from refresh is a repeat, only the first entry needs the sleep
   property p_sleep_first;
      (speed_sel == SPD_1000) && $rose(tx_quiet) && !$past(tx_refresh) |-> $past(tx_send_sleep);
   endproperty
   a_sleep_first: assert property (p_sleep_first) else $error("quiet without sleep");
   property p_refresh;
      $rose(tx_refresh) |-> $past(tx_quiet);
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh not after quiet");
   property p_to_far;
      eee && $past(eee) |-> tx_lpi_to_far == $past(req);
   endproperty
   a_to_far: assert property (p_to_far) else $error("idle not passed on");
   property p_rx_idle;
      eee && rx_lpi_status |-> !rx_dv && rx_er && (rxd[3:0] == LPI_CODE_100)
         && ((speed_sel == SPD_100) || (rxd == LPI_CODE_1000));
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("bad receive idle code");
   property p_rx_off;
      rx_path_off |-> rx_lpi_status && !rx_dv;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receive off without idle");
   property p_wake_len;
      wk_q |-> wk_cnt_q <= lim;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake too long");
   property p_wake_cause;
      wake_done |-> wk_q ##1 !wake_done;
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("stray wake pulse");
   property p_ten;
      ten_reduced_active |-> $past(ten_meg_reduced_amplitude_enable);
   endproperty
   a_ten: assert property (p_ten) else $error("reduced mode not enabled");
endmodule : eee_lpi_ctrl_asserts

bind eee_lpi_ctrl eee_lpi_ctrl_asserts #(
   .WAKE100_CYCLES(WAKE100_CYCLES), .WAKE1000_CYCLES(WAKE1000_CYCLES)
) i_asserts (
   .clock(clock), .resetn(resetn), .speed_sel(speed_sel),
   .ten_meg_reduced_amplitude_enable(ten_meg_reduced_amplitude_enable),
   .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
   .tx_quiet(tx_quiet), .tx_refresh(tx_refresh), .tx_send_sleep(tx_send_sleep),
   .tx_lpi_to_far(tx_lpi_to_far), .rx_path_off(rx_path_off), .tx_lpi_status(tx_lpi_status),
   .rx_lpi_status(rx_lpi_status), .wake_done(wake_done), .ten_reduced_active(ten_reduced_active)
);

// >>> tb/eee_mac_model.sv
// mac-side model driving the transmit lanes
`timescale 1ns/1ps
module eee_mac_model
   import eee_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // bench commands
   input wire logic lpi_req,
   input wire logic frame_req,
   // wake completion from the phy
   input wire logic wake_done,
   // transmit lanes
   output logic tx_en,
   output logic tx_er,
   output logic [7:0] txd
);
   // frames wait until the phy has finished waking
   logic ok_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ok_q <= 1'b1;
      end else if (lpi_req) begin
         ok_q <= 1'b0;
      end else if (wake_done) begin
         ok_q <= 1'b1;
      end
   end
   // idle code held steadily; its low nibble serves the 100m lanes
   assign tx_en = frame_req && ok_q && !lpi_req;
   assign tx_er = lpi_req;
   assign txd = lpi_req ? LPI_CODE_1000 : (tx_en ? 8'hA5 : 8'h00);
endmodule : eee_mac_model

// >>> tb/test_eee_lpi_ctrl.sv
// self-checking bench of the low-power-idle controller
`timescale 1ns/1ps
module test_eee_lpi_ctrl import eee_pkg::*; ;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] speed_sel = SPD_100;
   logic ten_en = 1'b0, marginal = 1'b0, p_sleep = 1'b0, p_lpi = 1'b0;
   logic lpi_req = 1'b0, frame_req = 1'b0, line_dv = 1'b0, line_er = 1'b0;
   logic [7:0] line_data = 8'h00;
   logic tx_en, tx_er, rx_dv, rx_er, tx_quiet, tx_refresh, tx_send_sleep, to_far;
   logic rx_off, tx_lpi, rx_lpi, wake_done, ten_act;
   logic [7:0] txd, rxd;
   int mismatches = 0;
   int total_checks = 0;
   int n;
   // 200 mhz clock
   initial begin
      forever #2.5 clock = ~clock;
   end
   // ----------------------------------------
   // instances
   // ----------------------------------------
   eee_mac_model i_mac (.clock(clock), .resetn(resetn), .lpi_req(lpi_req),
      .frame_req(frame_req), .wake_done(wake_done), .tx_en(tx_en), .tx_er(tx_er), .txd(txd));
   eee_lpi_ctrl #(.QUIET_CYCLES(20), .WAKE100_CYCLES(10), .WAKE1000_CYCLES(8)) i_dut (
      .clock(clock), .resetn(resetn), .speed_sel(speed_sel),
      .ten_meg_reduced_amplitude_enable(ten_en), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
      .partner_sleep(p_sleep), .partner_lpi(p_lpi), .link_marginal(marginal),
      .rx_line_data(line_data), .rx_line_dv(line_dv), .rx_line_er(line_er), .rx_dv(rx_dv),
      .rx_er(rx_er), .rxd(rxd), .tx_quiet(tx_quiet), .tx_refresh(tx_refresh),
      .tx_send_sleep(tx_send_sleep), .tx_lpi_to_far(to_far), .rx_path_off(rx_off),
      .tx_lpi_status(tx_lpi), .rx_lpi_status(rx_lpi), .wake_done(wake_done),
      .ten_reduced_active(ten_act));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc
   // bounded wait for a level, counting falling edges
   task automatic wait_for(ref logic sig, input int lim);
      n = 0;
      while (sig !== 1'b1 && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask : wait_for
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_lpi_100;
      lpi_req = 1'b1;
      cyc(2);
      check({tx_quiet, tx_lpi, to_far}, 3'h7);
      wait_for(tx_refresh, 40);
      check(n >= 14 && n <= 21, 1'b1);
      wait_for(tx_quiet, 80);
      check(tx_quiet, 1'b1);
      lpi_req = 1'b0;
      frame_req = 1'b1;
      wait_for(wake_done, 40);
      check(n <= 12, 1'b1);
      cyc(2);
      check({tx_quiet, tx_lpi, tx_en}, 3'h1);
      frame_req = 1'b0;
   endtask : t_lpi_100
   task automatic t_lpi_1000;
      speed_sel = SPD_1000;
      lpi_req = 1'b1;
      cyc(8);
      check({tx_send_sleep, tx_quiet, to_far}, 3'h5);
      p_sleep = 1'b1;
      p_lpi = 1'b1;
      cyc(8);
      check({tx_quiet, rx_lpi, rx_dv, rx_er, rxd}, {4'hD, 8'h01});
      lpi_req = 1'b0;
      wait_for(wake_done, 40);
      check(n <= 10, 1'b1);
      p_sleep = 1'b0;
      p_lpi = 1'b0;
      cyc(8);
      check({rx_lpi, rx_off}, 2'h0);
   endtask : t_lpi_1000
   task automatic t_rx_idle;
      speed_sel = SPD_100;
      p_lpi = 1'b1;
      cyc(8);
      check({rx_off, rx_lpi, tx_lpi, rx_dv, rx_er, rxd[3:0]}, 9'h191);
      p_lpi = 1'b0;
      line_dv = 1'b1;
      line_data = 8'h5A;
      cyc(8);
      check({rx_off, rx_dv, rxd}, {2'h1, 8'h5A});
      line_dv = 1'b0;
   endtask : t_rx_idle
   task automatic t_ten;
      speed_sel = SPD_10;
      ten_en = 1'b1;
      cyc(8);
      check(ten_act, 1'b1);
      marginal = 1'b1;
      cyc(8);
      check(ten_act, 1'b0);
   endtask : t_ten
   // main sequence: reset for ten cycles, then the scenarios
   initial begin
      cyc(10);
      resetn = 1'b1;
      cyc(2);
      check({tx_quiet, wake_done, rx_dv}, 3'h0);
      t_lpi_100();
      t_lpi_1000();
      t_rx_idle();
      t_ten();
      end_of_test();
   end
   // watchdog well beyond the expected run
   initial begin
      #50000;
      mismatches++;
      end_of_test();
   end
endmodule : test_eee_lpi_ctrl
